// [pio_ctrl.sv]
// Pin I/O control, global routing select and programming safety
//
// Overview of operation
// - Each routing signal ANDed with its select bit
// - Groups receive only selected routing signals
// - Dedicated, pin and macrocell signals feed routing
// - Each pin set as input, output or both
// - Pin enable: global enable, constant low, high
// - Six global enables from dedicated, pin, macrocell
// - Low enable tristates; high enable drives once programmed, outside sessions
// - Pin and macrocell feedback are separate paths
// - Input pin leaves macrocell usable for routing
// - Programming tristates every pin with pull-up
// - Complete flag last; no driving until set
// - Dedicated inputs: clock, clear, two enable sources
// - Register clear optionally from global clear low
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pio_ctrl
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // APB slave
  input wire logic [pio_pkg::AW-1:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [pio_pkg::DW-1:0] i_pwdata,
  output logic [pio_pkg::DW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Programming port status from the test-port controller
  input wire logic i_prog_active,
  // Dedicated inputs
  input wire logic [pio_pkg::NDED-1:0] i_ded,
  // Macrocell results
  input wire logic [pio_pkg::NPIN-1:0] i_mc,
  // Pins
  input wire logic [pio_pkg::NPIN-1:0] i_pin_in,
  output logic [pio_pkg::NPIN-1:0] o_pin_out,
  output logic [pio_pkg::NPIN-1:0] o_pin_oe,
  output logic o_pin_pull_up,
  // Routing into logic block groups
  output logic [pio_pkg::NSRC-1:0] o_grp_in [pio_pkg::NGRP],
  // Per-macrocell register clear, active low
  output logic [pio_pkg::NPIN-1:0] o_mc_clr_n,
  // Programming complete flag
  output logic o_prog_done
);

  // APB handshake
  logic pready_q;
  logic pslverr_q;
  logic [pio_pkg::DW-1:0] prdata_q;
  logic setup;
  logic wr;

  // Configuration
  logic done_q;
  pio_pkg::pio_prog_e state_q;
  pio_pkg::pio_prog_e state_d;
  logic [pio_pkg::NPIN-1:0] clren_q;
  logic [pio_pkg::NSRC-1:0] grp_q [pio_pkg::NGRP];
  logic [pio_pkg::DW-1:0] pinoe_q;
  pio_pkg::pio_goe_cfg_s goe_q [pio_pkg::NGOE];

  // Datapath
  logic [pio_pkg::NSRC-1:0] bus;
  logic [pio_pkg::NGOE-1:0] goe;
  logic [pio_pkg::NPIN-1:0] oe;
  logic run;
  logic cfg_open;
  logic addr_ok;
  logic [pio_pkg::DW-1:0] rd_d;

  assign setup = i_psel & ~i_penable;
  assign wr = i_psel & i_penable & i_pwrite & pready_q;
  // Static configuration is only writable while programming
  assign cfg_open = (state_q == pio_pkg::PRG_ACTIVE);
  assign run = (state_q == pio_pkg::PRG_DONE) & ~i_prog_active;

  // Routing bus: macrocell and pin feedback kept apart
  assign bus = {i_mc, i_pin_in, i_ded};

  // Address decode
  always_comb
  begin
    addr_ok = (i_paddr[1:0] == 2'b00) && (i_paddr <= pio_pkg::A_LAST);
    rd_d = 32'h0000_0000;
    case (i_paddr)
      pio_pkg::A_CTRL:
      begin
        rd_d[pio_pkg::F_DONE] = done_q;
        rd_d[pio_pkg::F_PROG] = i_prog_active;
        rd_d[pio_pkg::F_RUN] = run;
      end
      pio_pkg::A_CLREN: rd_d[pio_pkg::NPIN-1:0] = clren_q;
      pio_pkg::A_GRP0: rd_d[pio_pkg::NSRC-1:0] = grp_q[0];
      pio_pkg::A_GRP1: rd_d[pio_pkg::NSRC-1:0] = grp_q[1];
      pio_pkg::A_PINOE: rd_d = pinoe_q;
      default:
      begin
        for (int k = 0; k < pio_pkg::NGOE; k++)
        begin
          if (i_paddr == pio_pkg::A_GOE0 + 12'(4 * k))
          begin
            rd_d[5:0] = goe_q[k];
          end
        end
      end
    endcase
  end

  // Zero wait state: ready in the first access cycle
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pready_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup & ~pready_q;
    end
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= addr_ok ? rd_d : 32'h0000_0000;
      pslverr_q <= ~addr_ok;
    end
  end

  // Programming sequence
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      pio_pkg::PRG_BLANK:
      begin
        if (i_prog_active)
        begin
          state_d = pio_pkg::PRG_ACTIVE;
        end
      end
      pio_pkg::PRG_ACTIVE:
      begin
        // Interrupted session stays blank
        if (!i_prog_active)
        begin
          state_d = done_q ? pio_pkg::PRG_DONE : pio_pkg::PRG_BLANK;
        end
      end
      pio_pkg::PRG_DONE:
      begin
        if (i_prog_active)
        begin
          state_d = pio_pkg::PRG_ACTIVE;
        end
      end
      default: state_d = pio_pkg::PRG_BLANK;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q <= pio_pkg::PRG_BLANK;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Complete flag: set by the last write of a session
  // Session start clears it; a set in that cycle cannot occur
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      done_q <= 1'b0;
    end
    else if (wr && cfg_open && i_paddr == pio_pkg::A_CTRL)
    begin
      done_q <= i_pwdata[pio_pkg::F_DONE];
    end
    else if (state_q != pio_pkg::PRG_ACTIVE && state_d == pio_pkg::PRG_ACTIVE)
    begin
      done_q <= 1'b0;
    end
  end

  // Configuration store
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      clren_q <= pio_pkg::RST_CLREN;
      grp_q[0] <= pio_pkg::RST_GRP;
      grp_q[1] <= pio_pkg::RST_GRP;
      pinoe_q <= pio_pkg::RST_PINOE;
    end
    else if (wr && cfg_open)
    begin
      case (i_paddr)
        pio_pkg::A_CLREN: clren_q <= i_pwdata[pio_pkg::NPIN-1:0];
        pio_pkg::A_GRP0: grp_q[0] <= i_pwdata[pio_pkg::NSRC-1:0];
        pio_pkg::A_GRP1: grp_q[1] <= i_pwdata[pio_pkg::NSRC-1:0];
        pio_pkg::A_PINOE: pinoe_q <= i_pwdata;
        default: clren_q <= clren_q;
      endcase
    end
  end

  // Global enable lines
  genvar g;
  generate
    for (g = 0; g < pio_pkg::NGOE; g++)
    begin : gen_goe
      logic src;
      always_ff @(posedge i_clk_sys or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          goe_q[g] <= pio_pkg::RST_GOE;
        end
        else if (wr && cfg_open &&
                 i_paddr == pio_pkg::A_GOE0 + 12'(4 * g))
        begin
          goe_q[g] <= i_pwdata[5:0];
        end
      end
      always_comb
      begin
        case (goe_q[g].kind)
          pio_pkg::GOE_DED0: src = i_ded[pio_pkg::DED_OE0];
          pio_pkg::GOE_DED1: src = i_ded[pio_pkg::DED_OE1];
          pio_pkg::GOE_PIN: src = i_pin_in[goe_q[g].idx];
          pio_pkg::GOE_MC: src = i_mc[goe_q[g].idx];
          default: src = 1'b0;
        endcase
      end
      // True or complement of the chosen source
      assign goe[g] = src ^ goe_q[g].inv;
    end
  endgenerate

  // Per-pin enable choice
  genvar p;
  generate
    for (p = 0; p < pio_pkg::NPIN; p++)
    begin : gen_pin
      logic [pio_pkg::OEW-1:0] sel;
      logic [pio_pkg::OEW-1:0] line;
      assign sel = pinoe_q[pio_pkg::OEW*p +: pio_pkg::OEW];
      assign line = sel - pio_pkg::OE_GOE0;
      always_comb
      begin
        if (sel == pio_pkg::OE_LOW)
        begin
          oe[p] = 1'b0;
        end
        else if (sel == pio_pkg::OE_HIGH)
        begin
          oe[p] = 1'b1;
        end
        else if (line < 4'(pio_pkg::NGOE))
        begin
          oe[p] = goe[line[2:0]];
        end
        else
        begin
          oe[p] = 1'b0;
        end
      end
    end
  endgenerate

  // Pin drivers: held off unless programmed and idle
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_pin_oe <= '0;
      o_pin_out <= '0;
      o_pin_pull_up <= 1'b0;
    end
    else
    begin
      o_pin_oe <= run ? oe : '0;
      o_pin_out <= i_mc;
      o_pin_pull_up <= i_prog_active;
    end
  end

  // Group routing: AND of signal and select bit
  genvar r;
  generate
    for (r = 0; r < pio_pkg::NGRP; r++)
    begin : gen_grp
      always_ff @(posedge i_clk_sys or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          o_grp_in[r] <= '0;
        end
        else
        begin
          o_grp_in[r] <= bus & grp_q[r];
        end
      end
    end
  endgenerate

  // Register clears from the global clear pin
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_mc_clr_n <= '1;
    end
    else
    begin
      o_mc_clr_n <= ~(clren_q & {pio_pkg::NPIN{~i_ded[pio_pkg::DED_CLR]}});
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_prog_done <= 1'b0;
    end
    else
    begin
      o_prog_done <= done_q;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;

endmodule
`default_nettype wire

// [pio_pkg.sv]
// Package: constants and types for the pin I/O control block
package pio_pkg;
  // Sizes
  localparam int NPIN = 8;
  localparam int NDED = 4;
  localparam int NGRP = 2;
  localparam int NGOE = 6;
  localparam int NSRC = NDED + 2 * NPIN;
  localparam int AW = 12;
  localparam int DW = 32;
  // Dedicated input roles
  localparam int DED_CLK = 0;
  localparam int DED_CLR = 1;
  localparam int DED_OE0 = 2;
  localparam int DED_OE1 = 3;
  // Register byte offsets
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_CLREN = 12'h004;
  localparam logic [11:0] A_GRP0 = 12'h008;
  localparam logic [11:0] A_GRP1 = 12'h00c;
  localparam logic [11:0] A_PINOE = 12'h010;
  localparam logic [11:0] A_GOE0 = 12'h014;
  localparam logic [11:0] A_LAST = 12'h028;
  // Control register fields
  localparam int F_DONE = 0;
  localparam int F_PROG = 1;
  localparam int F_RUN = 2;
  // Per-pin enable code width and fixed codes
  localparam int OEW = 4;
  localparam logic [3:0] OE_LOW = 4'h0;
  localparam logic [3:0] OE_HIGH = 4'h1;
  localparam logic [3:0] OE_GOE0 = 4'h2;
  // Reset values
  localparam logic [31:0] RST_PINOE = 32'h0000_0000;
  localparam logic [NSRC-1:0] RST_GRP = 20'h0_0000;
  localparam logic [NPIN-1:0] RST_CLREN = 8'h00;

  typedef enum logic [1:0] {
    GOE_DED0 = 2'b00,
    GOE_DED1 = 2'b01,
    GOE_PIN = 2'b10,
    GOE_MC = 2'b11
  } pio_goe_kind_e;

  typedef struct packed {
    logic [2:0] idx;
    logic inv;
    pio_goe_kind_e kind;
  } pio_goe_cfg_s;

  localparam pio_goe_cfg_s RST_GOE = 6'h00;

  typedef enum logic [1:0] {
    PRG_BLANK = 2'b00,
    PRG_ACTIVE = 2'b01,
    PRG_DONE = 2'b10
  } pio_prog_e;
endpackage

// [pio_ctrl_sva.sv]
// Assertion checker for the pin I/O control block
`timescale 1ns/1ps
`default_nettype none
module pio_ctrl_sva
(
  // Clock, reset, inputs
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_prog_active,
  input wire logic [pio_pkg::NDED-1:0] i_ded,
  input wire logic [pio_pkg::NPIN-1:0] i_mc,
  input wire logic [pio_pkg::NPIN-1:0] i_pin_in,
  // Outputs
  input wire logic o_pready,
  input wire logic [pio_pkg::NPIN-1:0] o_pin_oe,
  input wire logic o_pin_pull_up,
  input wire logic [pio_pkg::NSRC-1:0] o_grp_in [pio_pkg::NGRP],
  input wire logic [pio_pkg::NPIN-1:0] o_mc_clr_n,
  input wire logic o_prog_done
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready held");
  ready_setup_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no pready");
  pull_follow_a: assert property (i_prog_active |=> o_pin_pull_up)
    else $error("no pull-up");
  pull_drop_a: assert property (!i_prog_active |=> !o_pin_pull_up)
    else $error("pull-up stuck");
  prog_float_a: assert property (o_pin_pull_up |-> o_pin_oe == '0)
    else $error("drive in session");
  done_gate_a: assert property (!o_prog_done |-> o_pin_oe == '0)
    else $error("drive undone");
  clear_gate_a: assert property (i_ded[1] |=> &o_mc_clr_n)
    else $error("clear leak");
  route_mask_a: assert property (
    (o_grp_in[0] & ~$past({i_mc, i_pin_in, i_ded})) == '0)
    else $error("route leak");
  cover property (o_pin_pull_up ##1 !o_pin_pull_up);
  cover property (|o_pin_oe);
  cover property (!o_mc_clr_n[0]);
endmodule
bind pio_ctrl pio_ctrl_sva u_sva (.i_clk_sys, .i_reset_n, .i_psel,
  .i_penable, .i_prog_active, .i_ded, .i_mc, .i_pin_in, .o_pready,
  .o_pin_oe, .o_pin_pull_up, .o_grp_in, .o_mc_clr_n, .o_prog_done);
`default_nettype wire

// [pio_board.sv]
// Board model resolving pin levels
`timescale 1ns/1ps
`default_nettype none
module pio_board
(
  // Clock
  input wire logic i_clk_sys,
  // Device pin side
  input wire logic [7:0] i_pin_out,
  input wire logic [7:0] i_pin_oe,
  input wire logic i_pull_up,
  // Board drivers
  input wire logic [7:0] i_board_en,
  input wire logic [7:0] i_board_val,
  // Pin level
  output logic [7:0] o_pin_lvl
);
  logic [7:0] last_q = 8'h00;
  logic [7:0] free;
  always_ff @(posedge i_clk_sys)
    last_q <= o_pin_lvl;
  assign free = ~i_pin_oe & ~i_board_en;
  // Float without pull-up shows inverted last level, never a stale one; with pull-up it reads high
  assign o_pin_lvl = (i_pin_oe & i_pin_out)
    | (~i_pin_oe & i_board_en & i_board_val)
    | (free & {8{i_pull_up}})
    | (free & ~{8{i_pull_up}} & ~last_q);
endmodule
`default_nettype wire

// [pio_ctrl_tb_top.sv]
// Testbench for the pin I/O control block
`timescale 1ns/1ps
`default_nettype none
module pio_ctrl_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic prog = 1'b0;
  logic [3:0] ded = 4'hf;
  logic [7:0] mc = 8'h00;
  logic [7:0] bval = 8'h00;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] clr_n;
  logic pull_up;
  logic done;
  logic [19:0] grp [2];
  logic [31:0] q;
  logic e;
  int n_fail = 0;
  int checks_done = 0;

  always #50 clk = ~clk;

  pio_ctrl dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_paddr(paddr),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_prog_active(prog), .i_ded(ded), .i_mc(mc),
    .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_pin_pull_up(pull_up), .o_grp_in(grp), .o_mc_clr_n(clr_n),
    .o_prog_done(done));
  pio_board u_board (.i_clk_sys(clk), .i_pin_out(pin_out),
    .i_pin_oe(pin_oe), .i_pull_up(pull_up), .i_board_en(8'h02),
    .i_board_val(bval), .o_pin_lvl(pin_in));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // No cycle count assumed; only the watchdog ends a hang
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Config is only accepted inside a session
  task sess(input logic [5:0] goe, input logic fin);
    @(posedge clk);
    prog <= 1'b1;
    repeat (2) @(posedge clk);
    check(32'({pull_up, pin_oe}), 32'h100);
    xfer(1'b1, pio_pkg::A_GRP0, 32'h000f_ffff);
    xfer(1'b1, pio_pkg::A_GRP1, 32'h000f_f000);
    xfer(1'b1, pio_pkg::A_CLREN, 32'h0000_000f);
    xfer(1'b1, pio_pkg::A_PINOE, 32'h0000_8201);
    xfer(1'b1, pio_pkg::A_GOE0, {26'h0, goe});
    xfer(1'b0, pio_pkg::A_CTRL, 32'h0);
    check(q, 32'h2);
    // Flag goes last, and only once readback shows the session open
    if (fin && q[1])
      xfer(1'b1, pio_pkg::A_CTRL, 32'h1);
    @(posedge clk);
    prog <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task t_reset;
    check(32'({pull_up, done, clr_n, pin_oe}), 32'h0ff00);
    xfer(1'b1, pio_pkg::A_GRP0, 32'h000f_ffff);
    xfer(1'b0, pio_pkg::A_GRP0, 32'h0);
    check(q, 32'h0);
    xfer(1'b0, pio_pkg::A_LAST + 12'h004, 32'h0);
    check(32'(e), 32'h1);
    xfer(1'b0, 12'h002, 32'h0);
    check(32'(e), 32'h1);
  endtask

  task t_goe;
    logic b;
    for (int k = 0; k < 4; k++)
    begin
      sess({3'd1, 1'b1, 2'(k)}, 1'b1);
      check(32'(done), 32'h1);
      for (int v = 0; v < 2; v++)
      begin
        b = 1'(v);
        ded <= {(k == 1) ? b : ~b, (k == 0) ? b : ~b, 2'b11};
        bval <= {6'h0, (k == 2) ? b : ~b, 1'b0};
        mc <= {6'h0, (k == 3) ? b : ~b, b};
        repeat (3) @(posedge clk);
        check(32'(pin_oe[3:0]), {29'h0, ~b, 2'b01});
        check(32'(grp[1]), {12'h0, mc, 12'h0});
        check(32'(grp[0][5:0]), {26'h0, bval[1], b, ded});
      end
    end
    ded[1] <= 1'b0;
    repeat (2) @(posedge clk);
    check(32'(clr_n), 32'hf0);
    ded[1] <= 1'b1;
  endtask

  task t_abort;
    sess(6'h00, 1'b0);
    check(32'({done, pin_oe}), 32'h0);
    sess(6'h00, 1'b1);
    check(32'(pin_oe[1:0]), 32'h1);
    // Reset in mid-run must fall back to the blank, undriven state
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b0, pio_pkg::A_CTRL, 32'h0);
    check(q, 32'h0);
    check(32'({done, pin_oe}), 32'h0);
  endtask

  task final_report;
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_goe;
    t_abort;
    final_report;
  end

  initial
  begin
    #2000000;
    n_fail++;
    final_report;
  end
endmodule
`default_nettype wire
